// File: src/ssc_pkg.sv
// package: constants, states and classes for the sensor serial config link
// Function
// - slave answers only while chip select low
// - host alone makes and toggles serial clock
// - host drives mosi, sensor drives miso
// - serial clock 5 to 50 MHz, 40-60% duty
// - clock idles high, sample on rising edge
// - read fetch delay at most 1.5 us
// - host allows 4.5 us fetch while capturing
// - every write lands in shadow copy first
// - shadow applied at frame start or state entry
// - reads return shadow copy, not active value
// - setup-only write while capturing waits for setup
// - host prefers changing registers in setup state
// - three write classes, host respects each class
// - in standby write only state-select, soft-reset
package ssc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int REG_IDX_W = 6;
  localparam int REG_DEPTH = 64;
  // bit counter positions within one transfer
  localparam logic [5:0] ADDR_LAST_BIT = 6'h0f;
  localparam logic [5:0] DATA_FIRST_BIT = 6'h10;
  localparam logic [5:0] DATA_LAST_BIT = 6'h1f;
  localparam logic [5:0] FRAME_BITS = 6'h20;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] STATE_SEL_ADDR = 16'h4018;
  localparam logic [15:0] SOFT_RST_ADDR = 16'h4060;
  localparam logic [15:0] LINE_LENGTH_ADDR = 16'h0200;
  // timing
  localparam int MCLK_NS = 20;
  localparam int FETCH_NS = 1000;
  localparam int SETUP_WAIT_NS = 1500;
  localparam int CAPT_WAIT_NS = 4500;
  localparam logic [7:0] FETCH_CYC = 8'(FETCH_NS / MCLK_NS);
  localparam logic [7:0] SETUP_WAIT_CYC = 8'((SETUP_WAIT_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [7:0] CAPT_WAIT_CYC = 8'((CAPT_WAIT_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [1:0] SCK_HALF_CYC = 2'h3; // half period is this plus one mclk cycles
  typedef enum logic [1:0] {SSC_STANDBY, SSC_SETUP, SSC_IDLE, SSC_CAPTURE_ACTIVE} ssc_op_state_e;
  typedef enum logic [1:0] {SSC_CLS_ANY, SSC_CLS_IDLE_SETUP, SSC_CLS_SETUP_ONLY} ssc_class_e;

  // write class of a shadow entry
  function automatic ssc_class_e ssc_reg_class(input logic [5:0] idx);
    if (idx == STATE_SEL_ADDR[6:1]) begin
      return SSC_CLS_ANY;
    end
    unique case (idx[5:4])
      2'h3: return SSC_CLS_ANY;
      2'h2: return SSC_CLS_IDLE_SETUP;
      default: return SSC_CLS_SETUP_ONLY;
    endcase
  endfunction : ssc_reg_class

  // may a register of this class be set in this state
  function automatic logic ssc_apply_ok(input ssc_class_e cls, input ssc_op_state_e st);
    unique case (cls)
      SSC_CLS_ANY: return 1'b1;
      SSC_CLS_IDLE_SETUP: return (st == SSC_IDLE) || (st == SSC_SETUP);
      default: return st == SSC_SETUP;
    endcase
  endfunction : ssc_apply_ok

  // host-side write permission including the standby exception
  function automatic logic ssc_write_ok(input logic [15:0] addr, input ssc_op_state_e st);
    if (st == SSC_STANDBY) begin
      return (addr[15:1] == STATE_SEL_ADDR[15:1]) || (addr[15:1] == SOFT_RST_ADDR[15:1]);
    end
    return ssc_apply_ok(ssc_reg_class(addr[6:1]), st);
  endfunction : ssc_write_ok
endpackage : ssc_pkg

// File: src/ssc_link_if.sv
// interface: the four-wire serial link between host and sensor
interface ssc_link_if;
  logic sck;
  logic csn;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  // undriven miso reads as idle high
  assign miso = miso_oe ? miso_o : 1'b1;
  modport dev (input sck, input csn, input mosi, output miso_o, output miso_oe);
  modport host (output sck, output csn, output mosi, input miso);
endinterface : ssc_link_if

// File: src/ssc_sync2.sv
// two-flop synchroniser for levels and toggles
module ssc_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : ssc_sync2

// File: src/ssc_dev.sv
// sensor end: serial slave on the link clock, shadow and active settings on mclk
module ssc_dev (
  // core clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // link
  ssc_link_if.dev link,
  // sensor core side
  input wire logic frame_start,
  input wire ssc_pkg::ssc_op_state_e op_state,
  input wire logic [ssc_pkg::REG_IDX_W-1:0] act_idx,
  output logic [ssc_pkg::DATA_W-1:0] act_data
);
  import ssc_pkg::*;

  // link-domain state
  logic [5:0] bit_cnt_reg;
  logic [15:0] rx_reg;
  logic rd_flag_reg;
  logic [15:0] addr_hold_reg;
  logic [15:0] wr_data_hold_reg;
  logic rd_tgl_reg;
  logic wr_tgl_reg;
  logic [15:0] tx_reg;
  logic miso_reg;
  logic miso_oe_reg;
  // core-domain state
  logic [1:0] tgl_sync;
  logic rd_tgl_seen_reg;
  logic wr_tgl_seen_reg;
  logic [7:0] fetch_cnt_reg;
  logic fetch_busy_reg;
  logic [15:0] rd_word_reg;
  ssc_op_state_e op_state_prev_reg;
  // entries are picked by address bits 6:1, so addresses differing higher up alias
  logic [15:0] shadow_mem [REG_DEPTH];
  logic [15:0] active_mem [REG_DEPTH];
  logic [REG_DEPTH-1:0] pend_reg;
  logic [15:0] act_data_reg;

  // decoded link events
  wire [15:0] rx_word = {rx_reg[14:0], link.mosi};
  wire addr_done = bit_cnt_reg == ADDR_LAST_BIT;
  wire data_done = bit_cnt_reg == DATA_LAST_BIT;
  wire load_tx = (bit_cnt_reg == DATA_FIRST_BIT) && rd_flag_reg;
  wire tx_run = (bit_cnt_reg > DATA_FIRST_BIT) && rd_flag_reg;

  // bit counting and receive shift; chip select high holds it cleared
  // the counter stops at the frame end, so bits beyond the 32nd are ignored
  always_ff @(posedge link.sck or posedge link.csn) begin
    if (link.csn) begin
      bit_cnt_reg <= 6'h00;
      rx_reg <= DATA_RST;
      rd_flag_reg <= 1'b0;
    end else begin
      if (bit_cnt_reg != FRAME_BITS) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
      rx_reg <= rx_word;
      if (addr_done) begin
        rd_flag_reg <= ~link.mosi;
      end
    end
  end

  // address and write word held for the core domain, with toggles as events
  // a frame cut before its last bit never toggles the write event, so it is dropped
  always_ff @(posedge link.sck or negedge rst_b) begin
    if (!rst_b) begin
      addr_hold_reg <= DATA_RST;
      wr_data_hold_reg <= DATA_RST;
      rd_tgl_reg <= 1'b0;
      wr_tgl_reg <= 1'b0;
    end else if (!link.csn) begin
      if (addr_done) begin
        addr_hold_reg <= rx_word;
        rd_tgl_reg <= rd_tgl_reg ^ ~link.mosi;
      end
      if (data_done && !rd_flag_reg) begin
        wr_data_hold_reg <= rx_word;
        wr_tgl_reg <= ~wr_tgl_reg;
      end
    end
  end

  // read data leaves on falling edges; rd_word_reg is read across domains here,
  // which is safe only because the host waits out the fetch time before the
  // first data fall; a host that clocks early gets the previous word
  always_ff @(negedge link.sck or posedge link.csn) begin
    if (link.csn) begin
      tx_reg <= DATA_RST;
      miso_reg <= 1'b1;
      miso_oe_reg <= 1'b0;
    end else if (load_tx) begin
      tx_reg <= {rd_word_reg[14:0], 1'b0};
      miso_reg <= rd_word_reg[15];
      miso_oe_reg <= 1'b1;
    end else if (tx_run) begin
      tx_reg <= {tx_reg[14:0], 1'b0};
      miso_reg <= tx_reg[15];
    end
  end

  assign link.miso_o = miso_reg;
  assign link.miso_oe = miso_oe_reg;

  // link toggles into the core domain; the held address and write word change
  // at bit edges well before their toggle lands, so the core reads them
  // directly once the toggle has passed both flops
  ssc_sync2 #(.W(2)) u_tgl_sync (
    .clk(mclk),
    .rst_b(rst_b),
    .d({rd_tgl_reg, wr_tgl_reg}),
    .q(tgl_sync)
  );

  // core-domain decode
  // any op_state change applies entries whose class allows the state entered
  wire rd_evt = tgl_sync[1] != rd_tgl_seen_reg;
  wire wr_evt = tgl_sync[0] != wr_tgl_seen_reg;
  wire [REG_IDX_W-1:0] hold_idx = addr_hold_reg[6:1];
  wire state_chg = op_state != op_state_prev_reg;
  wire apply_evt = frame_start || state_chg;
  wire fetch_done = fetch_busy_reg && (fetch_cnt_reg == 8'h00);

  // event bookkeeping and the read fetch delay
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_tgl_seen_reg <= 1'b0;
      wr_tgl_seen_reg <= 1'b0;
      op_state_prev_reg <= SSC_STANDBY;
      fetch_cnt_reg <= 8'h00;
      fetch_busy_reg <= 1'b0;
    end else begin
      rd_tgl_seen_reg <= tgl_sync[1];
      wr_tgl_seen_reg <= tgl_sync[0];
      op_state_prev_reg <= op_state;
      if (rd_evt) begin
        fetch_cnt_reg <= FETCH_CYC;
        fetch_busy_reg <= 1'b1;
      end else if (fetch_done) begin
        fetch_busy_reg <= 1'b0;
      end else if (fetch_busy_reg) begin
        fetch_cnt_reg <= fetch_cnt_reg - 8'h01;
      end
    end
  end

  // readback word comes from the shadow copy once the fixed fetch count runs
  // out; the count stays well inside the shortest wait the host allows
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_word_reg <= DATA_RST;
    end else if (fetch_done) begin
      rd_word_reg <= shadow_mem[hold_idx];
    end
  end

  // per-entry apply strobes: an apply event in a state the entry's class allows
  wire [REG_DEPTH-1:0] apply_sel;
  for (genvar g = 0; g < REG_DEPTH; g++) begin : g_apply
    assign apply_sel[g] = apply_evt &&
      ssc_apply_ok(ssc_reg_class(REG_IDX_W'(g)), op_state);
  end

  // shadow writes and pending marks; a new write beats a same-cycle apply
  // and stays pending, so the newer word goes out at the next apply
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= '0;
      for (int i = 0; i < REG_DEPTH; i++) begin
        shadow_mem[i] <= DATA_RST;
      end
    end else begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        if (apply_sel[i]) begin
          pend_reg[i] <= 1'b0;
        end
      end
      if (wr_evt) begin
        shadow_mem[hold_idx] <= wr_data_hold_reg;
        pend_reg[hold_idx] <= 1'b1;
      end
    end
  end

  // pending shadow entries move to active at an apply event in a state their class allows
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        active_mem[i] <= DATA_RST;
      end
    end else begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        if (pend_reg[i] && apply_sel[i]) begin
          active_mem[i] <= shadow_mem[i];
        end
      end
    end
  end

  // core reads the settings in use
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      act_data_reg <= DATA_RST;
    end else begin
      act_data_reg <= active_mem[act_idx];
    end
  end

  assign act_data = act_data_reg;
endmodule : ssc_dev

// File: src/ssc_host.sv
// host end: serial master that makes the link clock from mclk
module ssc_host (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // link
  ssc_link_if.host link,
  // command side
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [ssc_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [ssc_pkg::DATA_W-1:0] cmd_wdata,
  input wire ssc_pkg::ssc_op_state_e op_state,
  output logic cmd_ready,
  output logic cmd_refused,
  // answer side
  output logic rsp_valid,
  output logic [ssc_pkg::DATA_W-1:0] rsp_rdata
);
  import ssc_pkg::*;

  typedef enum {H_IDLE, H_SHIFT, H_WAIT, H_GAP} ssc_host_state_e;

  ssc_host_state_e state_reg;
  logic [1:0] div_reg;
  logic [5:0] bit_reg;
  logic [31:0] tx_reg;
  logic [15:0] rx_reg;
  logic is_rd_reg;
  logic [7:0] wait_reg;
  logic sck_reg;
  logic csn_reg;
  logic mosi_reg;
  logic ready_reg;
  logic refused_reg;
  logic rsp_valid_reg;
  logic [15:0] rsp_rdata_reg;
  logic miso_s;

  // miso is a pin: two flops before use
  ssc_sync2 #(.W(1)) u_miso_sync (
    .clk(mclk),
    .rst_b(rst_b),
    .d(link.miso),
    .q(miso_s)
  );

  // decode
  wire tick = div_reg == SCK_HALF_CYC;
  wire take = cmd_valid && ready_reg;
  wire allowed = !cmd_write || ssc_write_ok(cmd_addr, op_state);
  wire [15:0] wire_addr = {cmd_addr[15:1], cmd_write};
  // shorter wait in setup state, the preferred state for changes
  wire [7:0] wait_len = (op_state == SSC_CAPTURE_ACTIVE) ? CAPT_WAIT_CYC : SETUP_WAIT_CYC;

  // transfer sequencer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= H_IDLE;
      div_reg <= 2'h0;
      bit_reg <= 6'h00;
      tx_reg <= '0;
      rx_reg <= DATA_RST;
      is_rd_reg <= 1'b0;
      wait_reg <= 8'h00;
      sck_reg <= 1'b1;
      csn_reg <= 1'b1;
      mosi_reg <= 1'b0;
      ready_reg <= 1'b1;
      refused_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_rdata_reg <= DATA_RST;
    end else begin
      refused_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      div_reg <= tick ? 2'h0 : div_reg + 2'h1;
      unique case (state_reg)
        H_IDLE: begin
          div_reg <= 2'h0;
          if (take && !allowed) begin
            refused_reg <= 1'b1;
          end else if (take) begin
            csn_reg <= 1'b0;
            tx_reg <= {wire_addr, cmd_wdata};
            is_rd_reg <= !cmd_write;
            bit_reg <= 6'h00;
            ready_reg <= 1'b0;
            state_reg <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (tick && sck_reg) begin
            sck_reg <= 1'b0;
            mosi_reg <= tx_reg[31];
            tx_reg <= {tx_reg[30:0], 1'b0};
          end else if (tick) begin
            sck_reg <= 1'b1;
            rx_reg <= {rx_reg[14:0], miso_s};
            bit_reg <= bit_reg + 6'h01;
            if (bit_reg == ADDR_LAST_BIT && is_rd_reg) begin
              wait_reg <= wait_len;
              state_reg <= H_WAIT;
            end else if (bit_reg == DATA_LAST_BIT) begin
              state_reg <= H_GAP;
            end
          end
        end
        H_WAIT: begin
          div_reg <= 2'h0;
          wait_reg <= wait_reg - 8'h01;
          if (wait_reg == 8'h00) begin
            state_reg <= H_SHIFT;
          end
        end
        H_GAP: begin
          if (tick) begin
            csn_reg <= 1'b1;
            rsp_valid_reg <= 1'b1;
            rsp_rdata_reg <= rx_reg;
            ready_reg <= 1'b1;
            state_reg <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign link.sck = sck_reg;
  assign link.csn = csn_reg;
  assign link.mosi = mosi_reg;
  assign cmd_ready = ready_reg;
  assign cmd_refused = refused_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rsp_rdata_reg;
endmodule : ssc_host

// File: verification/ssc_monitor.sv
// checker: timing and framing of the serial config link
module ssc_monitor (
  // core clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // link wires
  input wire logic sck,
  input wire logic csn,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sck_q;
  logic sck_rise;
  logic rd_frame;
  logic [5:0] rise_cnt;
  logic [7:0] high_cnt;
  // rise seen on the mclk samples of the link clock
  assign sck_rise = sck && !sck_q;
  // count rises and high time in a frame, note the read bit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sck_q <= 1'b1;
      rise_cnt <= 6'h00;
      high_cnt <= 8'h00;
      rd_frame <= 1'b0;
    end else begin
      sck_q <= sck;
      rise_cnt <= csn ? 6'h00 : rise_cnt + 6'(sck_rise);
      high_cnt <= (csn || !sck) ? 8'h00 : high_cnt + 8'h01;
      rd_frame <= csn ? 1'b0 : ((sck_rise && rise_cnt == 6'h0f) ? !mosi : rd_frame);
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // link clock rests high between frames
  idle_sck_a: assert property (csn |-> sck)
    else $error("link clock low outside a frame");
  miso_quiet_a: assert property (csn |-> !miso_oe)
    else $error("sensor drives miso while deselected");
  sck_half_a: assert property ($changed(sck) && !csn |=> $stable(sck) [*3])
    else $error("link clock half period too short");
  csn_lead_a: assert property ($fell(csn) |-> sck [*4] ##1 $fell(sck))
    else $error("first clock fall not four cycles after select");
  mosi_edge_a: assert property (!csn && !$past(csn) && $changed(mosi) |-> $fell(sck))
    else $error("mosi changed away from a clock fall");
  miso_edge_a: assert property (miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sck)
    else $error("miso changed while clock high");
  oe_read_a: assert property ($rose(miso_oe) |-> rd_frame && rise_cnt == 6'h10 && !sck)
    else $error("miso enabled outside read data phase");
  frame_len_a: assert property ($rose(csn) |-> rise_cnt == 6'h20)
    else $error("frame not 32 clock rises");
  // 8'h4b cycles is 1.5 us of fetch time
  fetch_wait_a: assert property ($fell(sck) && !csn && rd_frame && rise_cnt == 6'h10 |-> high_cnt >= 8'h4b)
    else $error("read data clocked before fetch time");
endmodule : ssc_monitor

// File: verification/tb_top.sv
// testbench: host and sensor ends joined by the serial link
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ssc_pkg::*;
  logic mclk, rst_b, cmd_valid, cmd_write, cmd_ready, cmd_refused, rsp_valid, frame_start, rf;
  logic [15:0] cmd_addr, cmd_wdata, rsp_rdata, act_data, rd;
  logic [5:0] act_idx;
  ssc_op_state_e host_state, dev_state;
  int failures, checks_done;
  // permission table: host state, address, refusal expected
  ssc_op_state_e st_t [7] = '{SSC_STANDBY, SSC_STANDBY, SSC_STANDBY, SSC_IDLE, SSC_IDLE,
    SSC_CAPTURE_ACTIVE, SSC_CAPTURE_ACTIVE};
  logic [15:0] ad_t [7] = '{16'h0200, 16'h4018, 16'h4060, 16'h0200, 16'h0040, 16'h0040, 16'h0060};
  logic rj_t [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  ssc_link_if link();
  ssc_dev i_ssc_dev (.mclk(mclk), .rst_b(rst_b), .link(link.dev), .frame_start(frame_start),
    .op_state(dev_state), .act_idx(act_idx), .act_data(act_data));
  ssc_host i_ssc_host (.mclk(mclk), .rst_b(rst_b), .link(link.host), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .op_state(host_state),
    .cmd_ready(cmd_ready), .cmd_refused(cmd_refused), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  ssc_monitor i_ssc_monitor (.mclk(mclk), .rst_b(rst_b), .sck(link.sck), .csn(link.csn),
    .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe));
  // 50 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error t=%0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // one command through the host, waits for answer or refusal
  task automatic do_cmd(input logic wr, input logic [15:0] a, input logic [15:0] d,
      output logic [15:0] q, output logic refused);
    int n;
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge mclk);
    while (cmd_ready !== 1'b1) @(posedge mclk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp_valid !== 1'b1 && cmd_refused !== 1'b1 && n < 1000);
    if (n >= 1000) check(16'h0001, 16'h0000, "no answer");
    q = rsp_rdata;
    refused = cmd_refused;
  endtask : do_cmd
  // look at one active setting
  task automatic act_chk(input logic [5:0] idx, input logic [15:0] exp);
    act_idx <= idx;
    repeat (3) @(posedge mclk);
    check(act_data, exp, "active value");
  endtask : act_chk
  task automatic pulse_frame();
    frame_start <= 1'b1;
    @(posedge mclk);
    frame_start <= 1'b0;
  endtask : pulse_frame
  // watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge mclk);
    failures++;
    $display("Error t=%0t watchdog expired", $time);
    finish_test();
  end
  // main sequence
  initial begin
    {rst_b, cmd_valid, cmd_write, frame_start} = 4'h0;
    {cmd_addr, cmd_wdata, act_idx} = '0;
    host_state = SSC_SETUP;
    dev_state = SSC_SETUP;
    {failures, checks_done} = '0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    act_chk(6'h00, 16'h0000);
    do_cmd(1'b0, LINE_LENGTH_ADDR, 16'h0000, rd, rf);
    check(rd, 16'h0000, "reset readback");
    $display("test reset done");
    do_cmd(1'b1, LINE_LENGTH_ADDR, 16'h1234, rd, rf);
    do_cmd(1'b0, LINE_LENGTH_ADDR, 16'h0000, rd, rf);
    check(rd, 16'h1234, "shadow readback");
    act_chk(6'h00, 16'h0000);
    pulse_frame();
    act_chk(6'h00, 16'h1234);
    $display("test setup write done");
    dev_state <= SSC_CAPTURE_ACTIVE;
    do_cmd(1'b1, LINE_LENGTH_ADDR, 16'habcd, rd, rf);
    host_state <= SSC_CAPTURE_ACTIVE;
    do_cmd(1'b0, LINE_LENGTH_ADDR, 16'h0000, rd, rf);
    check(rd, 16'habcd, "capture readback");
    pulse_frame();
    act_chk(6'h00, 16'h1234);
    dev_state <= SSC_SETUP;
    act_chk(6'h00, 16'habcd);
    $display("test capture write done");
    for (int i = 0; i < 7; i++) begin
      host_state <= st_t[i];
      do_cmd(1'b1, ad_t[i], 16'h0000, rd, rf);
      check({15'h0000, rf}, {15'h0000, rj_t[i]}, "refusal");
      check({15'h0000, cmd_ready}, 16'h0001, "ready after answer");
    end
    $display("test permissions done");
    finish_test();
  end
endmodule : tb_top
